// *** core/bld_consts.svh ***
// Constants for the branch, move, bit-clear and return decoder.
// Assumes it is included by bare name from the core file.
`ifndef BLD_CONSTS_SVH
`define BLD_CONSTS_SVH

// Exact opcodes
`define BLD_OP_NOP        8'h04
`define BLD_OP_RET        8'hCD
`define BLD_OP_LDI_A      8'h17
`define BLD_OP_LDI_DS     8'h0D
`define BLD_OP_MV_A_IX    8'h07
`define BLD_OP_MV_A_IY    8'h0F
`define BLD_OP_MV_IX_A    8'h87
`define BLD_OP_MV_IY_A    8'h8F
`define BLD_OP_MV_A_DIR   8'h1F
`define BLD_OP_MV_DIR_A   8'h9F
// Register moves: low six bits, top two bits pick the auxiliary register
`define BLD_OP_MV_A_R_LO  6'h35
`define BLD_OP_MV_R_A_LO  6'h3D

// Patterned opcodes (low bits)
`define BLD_PAT_BNZ       3'h0
`define BLD_PAT_BZ        3'h4
`define BLD_PAT_BTCLR     5'h03
`define BLD_PAT_BTSET     5'h13
`define BLD_PAT_CLRBIT    5'h0B

// Data-space addresses held inside the core
`define BLD_ADDR_ACC      8'hFF
`define BLD_ADDR_AUX_HI   6'h20

// Instruction lengths in bytes and cycles
`define BLD_LEN_1         2'h1
`define BLD_LEN_2         2'h2
`define BLD_LEN_3         2'h3
`define BLD_CYC_2         3'h2
`define BLD_CYC_4         3'h4
`define BLD_CYC_5         3'h5

// Relative branch reference points from the opcode address
`define BLD_REF_SHORT     4'h1
`define BLD_REF_LONG      4'h2

`endif

// *** core/bld_pkg.sv ***
// Types shared by the branch, move, bit-clear and return decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package bld_pkg;

    // Sequencer states
    typedef enum logic [0:0] {
        ST_FETCH,
        ST_RUN
    } bld_fsm_e;

    // Decoded instruction classes
    typedef enum logic [3:0] {
        K_UNK,
        K_BNZ,
        K_BZ,
        K_BTCLR,
        K_BTSET,
        K_MV_A_R,
        K_MV_R_A,
        K_MV_A_IND,
        K_MV_IND_A,
        K_MV_A_DIR,
        K_MV_DIR_A,
        K_LDI_A,
        K_LDI_DS,
        K_NOP,
        K_CLRBIT,
        K_RET
    } bld_kind_e;

endpackage : bld_pkg

// *** core/bld_core.sv ***
// Decode and execute for branches, moves, bit clear, idle and return.
// Assumes program memory and external data space answer in the same cycle.
//
// Operation
// - branch_if_nonzero adds displacement when zero flag clear; one byte, two cycles.
// - Short displacement is five bits in the opcode, reaching -15 to +16.
// - branch_if_zero_flag branches only when zero flag set; one byte, two cycles.
// - branch_if_bit_clear: selector plus 00011, address, offset; three bytes, five cycles.
// - branch_if_bit_one branches when selected bit is one; three bytes, five cycles.
// - Long displacement reaches -126 to +129.
// - Bit-test branches copy the tested bit to carry, zero flag kept.
// - register_move copies source to destination, sets zero, keeps carry; four cycles.
// - Single-byte moves between accumulator and four auxiliary registers.
// - Indirect moves through first two auxiliaries and direct moves with address byte.
// - immediate_move to accumulator: 17 then data; sets zero, keeps carry.
// - immediate_move to data space: 0D, address, data; auxiliaries at 80-83.
// - idle_opcode 04: one byte, two cycles, only the program counter advances.
// - clear_bit_op zeroes selected bit, accumulator at FF; flags kept.
// - subroutine_exit CD loads program counter from top of stack; two cycles.
// - subroutine_exit with empty stack falls through to the next instruction.
`timescale 1ns/1ns

module bld_core #(
    parameter int                   PCW         = 12,
    parameter int                   STACK_DEPTH = 4,
    parameter logic [PCW-1:0]       RESET_PC    = '0
) (
    // Clock and reset
    input  wire logic               SYS_CLK_I,
    input  wire logic               SRST_I,
    // Program memory
    output logic [PCW-1:0]          PROG_ADDR_O,
    input  wire logic [7:0]         PROG_DATA_I,
    // External data space
    output logic [7:0]              DS_ADDR_O,
    input  wire logic [7:0]         DS_RDATA_I,
    output logic [7:0]              DS_WDATA_O,
    output logic                    DS_WE_O,
    // Call side of the stack
    input  wire logic               CALL_PUSH_I,
    input  wire logic [PCW-1:0]     CALL_ADDR_I,
    // Core state
    output logic [PCW-1:0]          PC_O,
    output logic [7:0]              ACC_O,
    output logic                    ZERO_FLAG_O,
    output logic                    CARRY_FLAG_O,
    output logic                    INSTR_DONE_O,
    output logic                    UNSUP_O
);
    `include "bld_consts.svh"

    localparam int SLW = $clog2(STACK_DEPTH + 1);

    typedef struct packed {
        // Sequencer
        bld_pkg::bld_fsm_e              fsm;
        logic [2:0]                     cnt;
        // Instruction bytes
        bld_pkg::bld_kind_e             kind;
        logic [7:0]                     op;
        logic [7:0]                     b2;
        logic [7:0]                     b3;
        // Program counter and fetch address
        logic [PCW-1:0]                 pc;
        logic [PCW-1:0]                 fetch;
        // Registers and flags
        logic [7:0]                     acc;
        logic [3:0][7:0]                aux;
        logic                           zf;
        logic                           cf;
        // Return stack
        logic [SLW-1:0]                 lvl;
        logic [STACK_DEPTH-1:0][PCW-1:0] stk;
        // Data-space side
        logic [7:0]                     ds_addr;
        logic [7:0]                     ds_wdata;
        logic                           ds_we;
        // Status pulses
        logic                           done;
        logic                           unsup;
    } bld_state_s;

    bld_state_s s_q;
    bld_state_s s_d;

    // Opcode classifier; exact codes first since 04 shares the short-branch pattern
    function automatic bld_pkg::bld_kind_e decode(input logic [7:0] op);
        bld_pkg::bld_kind_e k;
        k = bld_pkg::K_UNK;
        if (op == `BLD_OP_NOP)                       k = bld_pkg::K_NOP;
        else if (op == `BLD_OP_RET)                  k = bld_pkg::K_RET;
        else if (op == `BLD_OP_LDI_A)                k = bld_pkg::K_LDI_A;
        else if (op == `BLD_OP_LDI_DS)               k = bld_pkg::K_LDI_DS;
        else if (op == `BLD_OP_MV_A_IX || op == `BLD_OP_MV_A_IY)
            k = bld_pkg::K_MV_A_IND;
        else if (op == `BLD_OP_MV_IX_A || op == `BLD_OP_MV_IY_A)
            k = bld_pkg::K_MV_IND_A;
        else if (op == `BLD_OP_MV_A_DIR)             k = bld_pkg::K_MV_A_DIR;
        else if (op == `BLD_OP_MV_DIR_A)             k = bld_pkg::K_MV_DIR_A;
        else if (op[5:0] == `BLD_OP_MV_A_R_LO)       k = bld_pkg::K_MV_A_R;
        else if (op[5:0] == `BLD_OP_MV_R_A_LO)       k = bld_pkg::K_MV_R_A;
        // Patterned classes last; their masks overlap the exact codes
        else if (op[4:0] == `BLD_PAT_BTCLR)          k = bld_pkg::K_BTCLR;
        else if (op[4:0] == `BLD_PAT_BTSET)          k = bld_pkg::K_BTSET;
        else if (op[4:0] == `BLD_PAT_CLRBIT)         k = bld_pkg::K_CLRBIT;
        else if (op[2:0] == `BLD_PAT_BNZ)            k = bld_pkg::K_BNZ;
        else if (op[2:0] == `BLD_PAT_BZ)             k = bld_pkg::K_BZ;
        return k;
    endfunction : decode

    // Instruction length in bytes
    function automatic logic [1:0] n_bytes(input bld_pkg::bld_kind_e k);
        case (k)
            bld_pkg::K_BTCLR,
            bld_pkg::K_BTSET,
            bld_pkg::K_LDI_DS:   n_bytes = `BLD_LEN_3;
            bld_pkg::K_MV_A_DIR,
            bld_pkg::K_MV_DIR_A,
            bld_pkg::K_LDI_A,
            bld_pkg::K_CLRBIT:   n_bytes = `BLD_LEN_2;
            default:             n_bytes = `BLD_LEN_1;
        endcase
    endfunction : n_bytes

    // Instruction length in cycles
    function automatic logic [2:0] n_cycles(input bld_pkg::bld_kind_e k);
        case (k)
            bld_pkg::K_BTCLR,
            bld_pkg::K_BTSET:    n_cycles = `BLD_CYC_5;
            bld_pkg::K_BNZ,
            bld_pkg::K_BZ,
            bld_pkg::K_NOP,
            bld_pkg::K_RET,
            bld_pkg::K_UNK:      n_cycles = `BLD_CYC_2;
            default:             n_cycles = `BLD_CYC_4;
        endcase
    endfunction : n_cycles

    // Data-space read: accumulator and auxiliaries live here, the rest outside
    function automatic logic [7:0] ds_read(input logic [7:0] a, input logic [7:0] acc,
                                           input logic [3:0][7:0] aux, input logic [7:0] ext);
        if (a == `BLD_ADDR_ACC)              ds_read = acc;
        else if (a[7:2] == `BLD_ADDR_AUX_HI) ds_read = aux[a[1:0]];
        else                                 ds_read = ext;
    endfunction : ds_read

    // Views of the current instruction
    logic [2:0]         cyc;
    logic [PCW-1:0]     fall_pc;
    logic [PCW-1:0]     short_tgt;
    logic [PCW-1:0]     long_tgt;
    logic [7:0]         rd;
    logic               tbit;

    // Operand views shared by the execute step
    always_comb begin
        cyc       = n_cycles(s_q.kind);
        fall_pc   = s_q.pc + PCW'(n_bytes(s_q.kind));
        short_tgt = s_q.pc + PCW'(`BLD_REF_SHORT) + {{(PCW-5){s_q.op[7]}}, s_q.op[7:3]};
        long_tgt  = s_q.pc + PCW'(`BLD_REF_LONG) + {{(PCW-8){s_q.b3[7]}}, s_q.b3};
        rd        = ds_read(s_q.ds_addr, s_q.acc, s_q.aux, DS_RDATA_I);
        tbit      = rd[s_q.op[7:5]];
    end

    // Shared write port request
    logic               wr_en;
    logic [7:0]         wr_addr;
    logic [7:0]         wr_val;

    // Sequencer and execute; one write port keeps data-space stores, internal or external, in one place
    always_comb begin
        s_d      = s_q;
        wr_en    = 1'b0;
        wr_addr  = s_q.ds_addr;
        wr_val   = s_q.acc;
        // Strobes and pulses last one cycle
        s_d.ds_we = 1'b0;
        s_d.done  = 1'b0;
        s_d.unsup = 1'b0;

        // Fetch takes the opcode; run counts the remaining cycles
        case (s_q.fsm)
            bld_pkg::ST_FETCH: begin
                // Operand bytes follow in the run state
                s_d.op    = PROG_DATA_I;
                s_d.kind  = decode(PROG_DATA_I);
                s_d.fetch = s_q.fetch + PCW'(1);
                s_d.cnt   = 3'h1;
                s_d.fsm   = bld_pkg::ST_RUN;
            end
            bld_pkg::ST_RUN: begin
                s_d.cnt = s_q.cnt + 3'h1;
                // Operand bytes follow the opcode, one per cycle
                if (s_q.cnt == 3'h1 && n_bytes(s_q.kind) > `BLD_LEN_1) begin
                    s_d.b2    = PROG_DATA_I;
                    s_d.fetch = s_q.fetch + PCW'(1);
                end
                if (s_q.cnt == 3'h2 && n_bytes(s_q.kind) > `BLD_LEN_2) begin
                    s_d.b3    = PROG_DATA_I;
                    s_d.fetch = s_q.fetch + PCW'(1);
                end
                // Present the data-space address a cycle ahead of the read
                if (s_q.cnt == cyc - 3'h2) begin
                    case (s_q.kind)
                        bld_pkg::K_MV_A_IND,
                        bld_pkg::K_MV_IND_A: s_d.ds_addr = s_q.aux[{1'b0, s_q.op[3]}];
                        bld_pkg::K_MV_A_DIR,
                        bld_pkg::K_MV_DIR_A,
                        bld_pkg::K_BTCLR,
                        bld_pkg::K_BTSET,
                        bld_pkg::K_CLRBIT:   s_d.ds_addr = s_q.b2;
                        default:             s_d.ds_addr = s_q.ds_addr;
                    endcase
                end

                // Last cycle: execute, then hand over to the next fetch
                if (s_q.cnt == cyc - 3'h1) begin
                    // Fall through unless a branch or return says otherwise
                    s_d.pc    = fall_pc;
                    s_d.fsm   = bld_pkg::ST_FETCH;
                    s_d.done  = 1'b1;
                    case (s_q.kind)
                        // Short branches test the zero flag and leave both flags
                        bld_pkg::K_BNZ:
                            if (!s_q.zf) s_d.pc = short_tgt;
                        bld_pkg::K_BZ:
                            if (s_q.zf) s_d.pc = short_tgt;

                        // Bit tests load carry whether or not they branch
                        bld_pkg::K_BTCLR: begin
                            s_d.cf = tbit;
                            if (!tbit) s_d.pc = long_tgt;
                        end
                        bld_pkg::K_BTSET: begin
                            s_d.cf = tbit;
                            if (tbit) s_d.pc = long_tgt;
                        end

                        // Register moves never leave the core
                        bld_pkg::K_MV_A_R: begin
                            s_d.acc = s_q.aux[s_q.op[7:6]];
                            s_d.zf  = (s_q.aux[s_q.op[7:6]] == 8'h00);
                        end
                        bld_pkg::K_MV_R_A: begin
                            s_d.aux[s_q.op[7:6]] = s_q.acc;
                            s_d.zf  = (s_q.acc == 8'h00);
                        end

                        // Loads take the byte read in this cycle
                        bld_pkg::K_MV_A_IND,
                        bld_pkg::K_MV_A_DIR: begin
                            s_d.acc = rd;
                            s_d.zf  = (rd == 8'h00);
                        end

                        // Stores use the shared write port below
                        bld_pkg::K_MV_IND_A,
                        bld_pkg::K_MV_DIR_A: begin
                            wr_en  = 1'b1;
                            s_d.zf = (s_q.acc == 8'h00);
                        end

                        // Only the accumulator form of the immediate load sets zero
                        bld_pkg::K_LDI_A: begin
                            s_d.acc = s_q.b2;
                            s_d.zf  = (s_q.b2 == 8'h00);
                        end
                        bld_pkg::K_LDI_DS: begin
                            wr_en   = 1'b1;
                            wr_addr = s_q.b2;
                            wr_val  = s_q.b3;
                        end

                        // Read, clear and write back through one address
                        bld_pkg::K_CLRBIT: begin
                            wr_en  = 1'b1;
                            wr_val = rd & ~(8'h01 << s_q.op[7:5]);
                        end

                        // Pop only a pushed entry; an empty stack falls through
                        bld_pkg::K_RET:
                            if (s_q.lvl != '0) begin
                                s_d.pc  = s_q.stk[s_q.lvl - SLW'(1)];
                                s_d.lvl = s_q.lvl - SLW'(1);
                            end

                        // Unknown opcodes behave as a two-cycle idle
                        bld_pkg::K_UNK:
                            s_d.unsup = 1'b1;
                        default: ;
                    endcase
                    // Next fetch follows the chosen program counter
                    s_d.fetch = s_d.pc;
                end
            end
            default: s_d.fsm = bld_pkg::ST_FETCH;
        endcase

        // Single data-space write port
        if (wr_en) begin
            if (wr_addr == `BLD_ADDR_ACC)              s_d.acc = wr_val;
            else if (wr_addr[7:2] == `BLD_ADDR_AUX_HI) s_d.aux[wr_addr[1:0]] = wr_val;
            else begin
                s_d.ds_we    = 1'b1;
                s_d.ds_addr  = wr_addr;
                s_d.ds_wdata = wr_val;
            end
        end

        // Call push after any pop; a push into a full stack is dropped
        if (CALL_PUSH_I && s_d.lvl < SLW'(STACK_DEPTH)) begin
            s_d.stk[s_d.lvl] = CALL_ADDR_I;
            s_d.lvl          = s_d.lvl + SLW'(1);
        end

        // Synchronous reset overrides everything above
        if (SRST_I) begin
            s_d       = '0;
            s_d.pc    = RESET_PC;
            s_d.fetch = RESET_PC;
        end
    end

    // State register
    always_ff @(posedge SYS_CLK_I) begin
        s_q <= s_d;
    end

    // Outputs straight from state
    assign PROG_ADDR_O  = s_q.fetch;
    assign DS_ADDR_O    = s_q.ds_addr;
    assign DS_WDATA_O   = s_q.ds_wdata;
    assign DS_WE_O      = s_q.ds_we;
    assign PC_O         = s_q.pc;
    assign ACC_O        = s_q.acc;
    assign ZERO_FLAG_O  = s_q.zf;
    assign CARRY_FLAG_O = s_q.cf;
    assign INSTR_DONE_O = s_q.done;
    assign UNSUP_O      = s_q.unsup;

endmodule : bld_core

// *** test/bld_core_chk.sv ***
// Port-level checks on the branch, move, bit-clear and return decoder.
// Assumes a bind onto bld_core and one clock domain with synchronous reset.
`timescale 1ns/1ns
module bld_core_chk #(
    parameter int PCW = 12
) (
    // Clock and reset
    input wire logic           SYS_CLK_I,
    input wire logic           SRST_I,
    // Memories
    input wire logic [7:0]     PROG_DATA_I,
    input wire logic [7:0]     DS_ADDR_O,
    input wire logic [7:0]     DS_RDATA_I,
    input wire logic           DS_WE_O,
    // Core state
    input wire logic [PCW-1:0] PC_O,
    input wire logic [7:0]     ACC_O,
    input wire logic           ZERO_FLAG_O,
    input wire logic           CARRY_FLAG_O,
    input wire logic           INSTR_DONE_O
);
    default clocking @(posedge SYS_CLK_I);
    endclocking
    default disable iff (SRST_I);

    // Opcode classes seen in a fetch cycle; 04 shares the short pattern
    logic       fetch_short;
    logic       fetch_btst;
    logic [1:0] zc;
    assign fetch_short = INSTR_DONE_O && PROG_DATA_I[1:0] == 2'h0 && PROG_DATA_I != 8'h04;
    assign fetch_btst  = INSTR_DONE_O && PROG_DATA_I[3:0] == 4'h3;
    assign zc          = {ZERO_FLAG_O, CARRY_FLAG_O};

    a_short_taken: assert property (
        fetch_short && PROG_DATA_I[2] == ZERO_FLAG_O |-> ##2 INSTR_DONE_O
        && PC_O == $past(PC_O, 2) + PCW'(signed'($past(PROG_DATA_I[7:3], 2))) + 1'b1)
        else $error("short branch target wrong");
    a_short_skip: assert property (
        fetch_short && PROG_DATA_I[2] != ZERO_FLAG_O |-> ##2 INSTR_DONE_O && PC_O == $past(PC_O, 2) + 1'b1)
        else $error("short branch fall through wrong");
    a_short_flags: assert property (
        fetch_short |=> $stable(zc) [*2])
        else $error("short branch touched flags");
    a_bit_carry: assert property (
        fetch_btst ##1 !PROG_DATA_I[7] |-> ##4 INSTR_DONE_O && ZERO_FLAG_O == $past(ZERO_FLAG_O, 5)
        && (($past(DS_RDATA_I) >> $past(PROG_DATA_I[7:5], 5)) & 8'h01) == {7'h00, CARRY_FLAG_O})
        else $error("bit test carry or length wrong");
    a_long_branch: assert property (
        fetch_btst ##1 !PROG_DATA_I[7] |-> ##4 PC_O == $past(PC_O, 5) + (CARRY_FLAG_O == $past(PROG_DATA_I[4], 5)
        ? PCW'(signed'($past(PROG_DATA_I, 3))) + 2'h2 : 2'h3))
        else $error("bit test target wrong");
    a_imm_acc: assert property (
        INSTR_DONE_O && PROG_DATA_I == 8'h17 |-> ##4 INSTR_DONE_O && ACC_O == $past(PROG_DATA_I, 3)
        && ZERO_FLAG_O == (ACC_O == 8'h00) && CARRY_FLAG_O == $past(CARRY_FLAG_O, 4))
        else $error("immediate load wrong");
    a_reg_move: assert property (
        INSTR_DONE_O && PROG_DATA_I[5:0] == 6'h35 |-> ##4 INSTR_DONE_O
        && ZERO_FLAG_O == (ACC_O == 8'h00) && CARRY_FLAG_O == $past(CARRY_FLAG_O, 4))
        else $error("register move wrong");
    a_idle_op: assert property (
        INSTR_DONE_O && PROG_DATA_I == 8'h04 |=> !INSTR_DONE_O ##1 INSTR_DONE_O
        && ACC_O == $past(ACC_O, 2) && zc == $past(zc, 2) && PC_O == $past(PC_O, 2) + 1'b1)
        else $error("idle opcode wrong");
    a_return_len: assert property (
        INSTR_DONE_O && PROG_DATA_I == 8'hCD |-> ##2 INSTR_DONE_O && zc == $past(zc, 2))
        else $error("return length or flags wrong");
    a_store_flags: assert property (
        INSTR_DONE_O && (PROG_DATA_I == 8'h0D || PROG_DATA_I[4:0] == 5'h0B) |-> ##4 INSTR_DONE_O
        && zc == $past(zc, 4))
        else $error("store touched flags");
    a_write_int: assert property (
        DS_WE_O |-> INSTR_DONE_O && DS_ADDR_O != 8'hFF && DS_ADDR_O[7:2] != 6'h20)
        else $error("write strobe misplaced");

    // Main scenarios reached
    c_short_taken: cover property (fetch_short && PROG_DATA_I[2] == ZERO_FLAG_O);
    c_bit_test: cover property (fetch_btst);
    c_return: cover property (INSTR_DONE_O && PROG_DATA_I == 8'hCD);
endmodule : bld_core_chk

bind bld_core bld_core_chk #(.PCW(PCW)) chk_u (
    .SYS_CLK_I(SYS_CLK_I), .SRST_I(SRST_I), .PROG_DATA_I(PROG_DATA_I), .DS_ADDR_O(DS_ADDR_O),
    .DS_RDATA_I(DS_RDATA_I), .DS_WE_O(DS_WE_O), .PC_O(PC_O), .ACC_O(ACC_O),
    .ZERO_FLAG_O(ZERO_FLAG_O), .CARRY_FLAG_O(CARRY_FLAG_O), .INSTR_DONE_O(INSTR_DONE_O));

// *** test/branch_load_bit_return_decoder_tb.sv ***
// Self-checking bench for the decoder core.
// Assumes bld_core with same-cycle program and data-space memories modelled here.
`timescale 1ns/1ns
module branch_load_bit_return_decoder_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        push = 1'b0;
    logic [11:0] push_a = 12'h000;
    logic [11:0] pa, pc_o, e_pc;
    logic [7:0]  pd, da, dr, dw, acc, e_a, la, lv;
    logic        we, zf, cf, done, e_z, e_c, uns;
    logic [7:0]  pm [0:4095];
    logic [7:0]  dm [0:255];
    logic [7:0]  em [0:255];
    logic [7:0]  aux [0:3];
    logic [11:0] stk [$];
    logic [31:0] seed = 32'd70439;
    int          err_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    // Memories answer in the same cycle
    assign pd = pm[pa];
    assign dr = dm[da];
    always #10 clk = ~clk;

    bld_core dut_u (.SYS_CLK_I(clk), .SRST_I(rst), .PROG_ADDR_O(pa), .PROG_DATA_I(pd), .DS_ADDR_O(da),
        .DS_RDATA_I(dr), .DS_WDATA_O(dw), .DS_WE_O(we), .CALL_PUSH_I(push), .CALL_ADDR_I(push_a),
        .PC_O(pc_o), .ACC_O(acc), .ZERO_FLAG_O(zf), .CARRY_FLAG_O(cf), .INSTR_DONE_O(done), .UNSUP_O(uns));

    // Writes land at the strobe; ceiling cuts a hang short
    always @(posedge clk) begin
        if (we === 1'b1) dm[da] <= dw;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d, errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [23:0] g, input logic [23:0] e, input string m);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk

    // Shift by a whole byte so successive draws are not plain shifts
    function automatic logic [7:0] rnd();
        repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction : rnd

    // Expected data space: FF is the accumulator, 80-83 the auxiliaries
    function automatic logic [7:0] rd(input logic [7:0] a);
        if (a == 8'hFF) return e_a;
        if (a[7:2] == 6'h20) return aux[a[1:0]];
        return em[a];
    endfunction : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        if (a == 8'hFF) e_a = v;
        else if (a[7:2] == 6'h20) aux[a[1:0]] = v;
        else begin
            em[a] = v;
            la = a;
        end
    endtask : wr

    task automatic call(input logic [11:0] a);
        push = 1'b1;
        push_a = a;
        if (stk.size() < 4) stk.push_back(a);
    endtask : call

    // Plant one instruction at the expected PC, model it, run it, compare
    task automatic exe(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
        logic [7:0]  t;
        logic [7:0]  ad;
        logic [11:0] off;
        logic [11:0] len;
        int          cyc;
        int          n;
        logic [7:0]  pl;
        // The previous store lands at the first edge; keep its address
        pl = la;
        pm[e_pc] = b0;
        pm[e_pc + 12'h001] = b1;
        pm[e_pc + 12'h002] = b2;
        off = 12'h000;
        len = 12'h001;
        cyc = 4;
        casez (b0)
            8'h04, 8'h6D: cyc = 2; // Idle, and one opcode left unsupported
            8'hCD: begin
                cyc = 2;
                if (stk.size() > 0) off = stk.pop_back() - e_pc - 12'h001;
            end
            8'b?????000, 8'b?????100: begin
                cyc = 2;
                if (b0[2] == e_z) off = {{7{b0[7]}}, b0[7:3]};
            end
            8'b????0011: begin
                t = rd(b1);
                e_c = t[b0[7:5]];
                cyc = 5;
                len = 12'h003;
                if (e_c == b0[4]) off = {{4{b2[7]}}, b2} - 12'h001;
            end
            8'b???01011: begin
                t = rd(b1);
                t[b0[7:5]] = 1'b0;
                wr(b1, t);
                len = 12'h002;
            end
            8'h17: begin
                e_a = b1;
                e_z = (b1 == 8'h00);
                len = 12'h002;
            end
            8'h0D: begin
                wr(b1, b2);
                len = 12'h003;
            end
            default: begin
                ad = b0[4] ? {6'h20, b0[7:6]} : aux[b0[3]];
                if (b0[4:0] == 5'h1F) ad = b1;
                if (b0[4:0] == 5'h1F) len = 12'h002;
                if (b0[4:0] == 5'h1F || !b0[4] ? !b0[7] : !b0[3]) e_a = rd(ad);
                else wr(ad, e_a);
                e_z = (e_a == 8'h00);
            end
        endcase
        e_pc = e_pc + len + off;
        n = 0;
        do begin
            @(posedge clk);
            #2;
            n++;
            if (n == 1) begin
                push = 1'b0;
                chk(dm[pl], lv, "data space");
            end
        end while (done !== 1'b1 && n < 40);
        chk(24'(n), 24'(cyc), "cycle count");
        chk(24'(uns), 24'(b0 == 8'h6D), "unsupported flag");
        chk(pc_o, e_pc, "program counter");
        chk(acc, e_a, "accumulator");
        chk({zf, cf}, {e_z, e_c}, "flags");
        lv = em[la];
    endtask : exe

    initial begin
        logic [7:0] r;
        for (int i = 0; i < 4096; i++) pm[i] = 8'h04;
        for (int i = 0; i < 256; i++) begin
            dm[i] = rnd();
            em[i] = dm[i];
        end
        aux = '{default: 8'h00};
        {e_pc, e_a, e_z, e_c, la} = '0;
        lv = em[0];
        repeat (3) @(posedge clk);
        #2;
        chk({done, zf, cf, pc_o, acc}, 24'h000000, "reset state");
        rst = 1'b0;
        exe(8'h17, 8'h00, 8'h00);
        // Every short field, zero flag varied
        for (int i = 0; i < 32; i++) begin
            exe(8'h17, (i % 3 == 0) ? 8'h00 : 8'h5A, 8'h00);
            exe({i[4:0], 3'h0}, rnd(), rnd());
            exe({i[4:0], 3'h4}, rnd(), rnd());
        end
        // Bit tests, first two with the extreme long offsets
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            exe({r[7:5], r[0], 4'h3}, rnd() & 8'h7F, (i < 2) ? {~i[0], {7{i[0]}}} : rnd());
        end
        exe(8'h53, 8'hFF, 8'h10);
        // Auxiliary loads, register moves and bit clear
        for (int k = 0; k < 4; k++) begin
            r = rnd();
            exe(8'h0D, {6'h20, k[1:0]}, {1'b0, r[6:0]});
            exe({k[1:0], 6'h35}, 8'h00, 8'h00);
            exe({r[7:5], 5'h0B}, (k == 3) ? 8'hFF : {1'b0, r[6:0]}, 8'h00);
            exe({k[1:0], 6'h3D}, 8'h00, 8'h00);
        end
        // Indirect and direct moves
        for (int k = 0; k < 2; k++) begin
            exe({4'h0, k[0], 3'h7}, 8'h00, 8'h00);
            exe(8'h17, rnd(), 8'h00);
            exe({4'h8, k[0], 3'h7}, 8'h00, 8'h00);
            exe(8'h1F, rnd(), 8'h00);
            exe(8'h9F, rnd(), 8'h00);
        end
        // Overfill the stack, then return past its bottom
        for (int k = 0; k < 5; k++) begin
            call({4'h1, k[3:0], 4'h0});
            exe(8'h04, 8'h00, 8'h00);
        end
        for (int k = 0; k < 5; k++) exe(8'hCD, 8'h00, 8'h00);
        exe(8'h04, 8'h00, 8'h00);
        exe(8'h6D, 8'h00, 8'h00);
        print_verdict();
    end
endmodule : branch_load_bit_return_decoder_tb
